// >>> hdl/timer_watchdog_pkg.sv
// Constants, carriers and state record of the timer/watchdog unit
package timer_watchdog_pkg;

   // -------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_CNT_HI = 8'h00;
   localparam logic [7:0] OFS_CNT_LO = 8'h04;
   localparam logic [7:0] OFS_PRESC = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0C;
   localparam logic [7:0] OFS_WCTRL = 8'h10;
   localparam logic [7:0] OFS_IVSEL = 8'h14;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int CB_RUN = 7;
   localparam int CB_SC = 6;
   localparam int CB_MODE_HI = 5;
   localparam int CB_MODE_LO = 4;
   localparam int CB_INPUT_ENABLE_BIT = 3;
   localparam int CB_OUTPUT_MODE_BIT = 2;
   localparam int CB_PWM = 1;
   localparam int CB_OUTPUT_ENABLE_BIT = 0;
   localparam int WB_WDEN_N = 6;
   localparam int IB_TLIS = 2;
   localparam int IB_IA0S = 1;

   // -------------------------------------------------------------
   // Encodings and values
   // -------------------------------------------------------------
   localparam logic [1:0] MODE_EVENT = 2'h0;
   localparam logic [1:0] MODE_GATED = 2'h1;
   localparam logic [1:0] MODE_TRIG = 2'h2;
   localparam logic [1:0] MODE_RETRIG = 2'h3;
   localparam logic [7:0] WDG_KEY1 = 8'hAA;
   localparam logic [7:0] WDG_KEY2 = 8'h55;
   localparam logic [15:0] CNT_RST = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [7:0] PRESC_RST = 8'hFF;
   localparam logic [7:0] PRE_ZERO = 8'h00;
   localparam logic [7:0] PRE_ONE = 8'h01;
   localparam logic [1:0] DIV_LAST = 2'h3;
   localparam logic [1:0] DIV_ONE = 2'h1;
   localparam logic [1:0] STRAP_CAP = 2'h2;
   localparam logic [1:0] STRAP_DONE = 2'h3;
   localparam logic [1:0] STRAP_ONE = 2'h1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // -------------------------------------------------------------
   // Bus carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } axi_rsp_s;

   // -------------------------------------------------------------
   // Whole state of the unit
   // -------------------------------------------------------------
   typedef struct packed {
      axi_rsp_s rsp;
      logic aw_full;
      logic w_full;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [1:0] sync_cnt;
      logic [1:0] sync_int;
      logic [1:0] sync_nmi;
      logic [1:0] sync_hw;
      logic cnt_prev;
      logic [1:0] div;
      logic [1:0] strap;
      logic hw_wdg;
      logic [15:0] cnt;
      logic [15:0] cons;
      logic cons_new;
      logic [7:0] presc;
      logic [7:0] pre;
      logic run;
      logic sc;
      logic [1:0] mode;
      logic input_enable_bit;
      logic output_mode_bit;
      logic pwm;
      logic output_enable_bit;
      logic wden_n;
      logic tlis;
      logic ia0s;
      logic armed;
      logic key_seen;
      logic wave;
      logic out;
      logic wdg_rst;
      logic top_irq;
      logic a0_irq;
   } state_s;

   localparam state_s STATE_RST = '{
      cnt: CNT_RST, cons: CNT_RST, presc: PRESC_RST, pre: PRESC_RST,
      mode: MODE_GATED, pwm: 1'b1, wden_n: 1'b1, tlis: 1'b1, ia0s: 1'b1,
      out: 1'b1, default: '0};

endpackage : timer_watchdog_pkg

// >>> hdl/timer_watchdog_unit.sv
// Timer/counter with prescaler and watchdog, AXI4-Lite register slave
// Contract
// - Sixteen-bit down-counter fed by an eight-bit prescaler.
// - Input enable counts external pin pulses, else internal clock divided by four.
// - Run bit starts counting next cycle, clear stops; restart resumes held value.
// - New constant loads at next zero; new prescaler acts at once.
// - Single mode: at zero stop, reload, clear run; stopped change loads at start.
// - Continuous mode: at zero reload and keep counting until run cleared.
// - Single/continuous bit writable anytime, also together with setting run.
// - Event mode counts falling input edges while run is set.
// - Gated mode counts clock/4 while input high and run set.
// - Triggerable mode counts clock/4 after run set and then falling edge.
// - Retriggerable: run starts; falling edge restarts from constant; ignored when stopped.
// - Output disabled drives wave output high.
// - Output enabled, mode clear: toggle output at each zero.
// - Output enabled, mode set: copy PWM level bit to output at zero.
// - Timer zero event routes to top-level or channel A0 instead of pin.
// - Hardware select low at reset forces watchdog, constant FFFFh, enable bit ignored.
// - Clearing active-low watchdog enable enters watchdog; software cannot set it back.
// - Watchdog entry starts counter from clock/4; only prescaler and interrupt select stay writable.
// - Watchdog reaching zero requests a system reset.
// - Writing AAh then 55h to low count register reloads and restarts watchdog.
// - Watchdog ignores halt, run, single and input mode bits; runs continuously.
// - Prescaler value 00h divides by 1, FFh divides by 256.
// - Input mode codes: 00 event, 01 gated (reset), 10 trigger, 11 retrigger.
// - Reset leaves watchdog disabled with active-low enable bit set.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module timer_watchdog_unit (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire timer_watchdog_pkg::axi_req_s axi_req,
   output timer_watchdog_pkg::axi_rsp_s axi_rsp,
   // Pins from outside
   input wire logic ext_count_input,
   input wire logic ext_int_pin,
   input wire logic nmi_pin,
   input wire logic hw_watchdog_select_pin,
   // Core status
   input wire logic cpu_halt,
   // Outputs
   output logic timer_wave_output,
   output logic wdg_reset_req,
   output logic top_level_irq,
   output logic chan_a0_irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   timer_watchdog_pkg::state_s s_q;
   timer_watchdog_pkg::state_s s_d;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Counting is evaluated first; a register write later in the same
   // cycle overrides it, so software always has the last word.
   always_comb begin
      logic div4;
      logic wdg;
      logic fall;
      logic tick;
      logic restart;
      logic eoc;
      logic eoc_irq;
      logic wr;
      logic rd;
      logic hit;
      logic [7:0] wb;
      logic [7:0] rb;
      div4 = 1'b0;
      wdg = 1'b0;
      fall = 1'b0;
      tick = 1'b0;
      restart = 1'b0;
      eoc = 1'b0;
      eoc_irq = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      hit = 1'b0;
      wb = 8'h00;
      rb = 8'h00;
      s_d = s_q;

      // Two-stage synchronisers; only the second stage is read
      s_d.sync_cnt = {s_q.sync_cnt[0], ext_count_input};
      s_d.sync_int = {s_q.sync_int[0], ext_int_pin};
      s_d.sync_nmi = {s_q.sync_nmi[0], nmi_pin};
      s_d.sync_hw = {s_q.sync_hw[0], hw_watchdog_select_pin};
      s_d.cnt_prev = s_q.sync_cnt[1];
      fall = s_q.cnt_prev & ~s_q.sync_cnt[1];

      // Internal clock divided by four as a one-cycle enable
      div4 = (s_q.div == timer_watchdog_pkg::DIV_LAST);
      s_d.div = s_q.div + timer_watchdog_pkg::DIV_ONE;

      // Strap capture once the synchroniser holds a settled level
      if (s_q.strap != timer_watchdog_pkg::STRAP_DONE) begin
         s_d.strap = s_q.strap + timer_watchdog_pkg::STRAP_ONE;
      end
      if (s_q.strap == timer_watchdog_pkg::STRAP_CAP) begin
         s_d.hw_wdg = ~s_q.sync_hw[1];
      end
      wdg = s_q.hw_wdg | ~s_q.wden_n;

      // Count source selection
      if (wdg) begin
         tick = div4;
      end else if (!s_q.run || cpu_halt) begin
         tick = 1'b0;
      end else if (!s_q.input_enable_bit) begin
         tick = div4;
      end else begin
         unique case (s_q.mode)
            timer_watchdog_pkg::MODE_EVENT: tick = fall;
            timer_watchdog_pkg::MODE_GATED: tick = div4 & s_q.sync_cnt[1];
            timer_watchdog_pkg::MODE_TRIG: tick = div4 & s_q.armed;
            timer_watchdog_pkg::MODE_RETRIG: begin
               tick = div4;
               restart = fall;
            end
         endcase
      end

      // Trigger arms on a falling edge only while running
      if (!s_q.run) begin
         s_d.armed = 1'b0;
      end else if (fall) begin
         s_d.armed = 1'b1;
      end

      // Prescaler and counter
      if (restart) begin
         s_d.cnt = s_q.cons;
         s_d.pre = s_q.presc;
         s_d.cons_new = 1'b0;
      end else if (tick) begin
         if (s_q.pre == timer_watchdog_pkg::PRE_ZERO) begin
            s_d.pre = s_q.presc;
            if (s_q.cnt == timer_watchdog_pkg::CNT_ZERO) begin
               eoc = 1'b1;
               s_d.cnt = s_q.cons;
               s_d.cons_new = 1'b0;
               if (!wdg && s_q.sc) begin
                  s_d.run = 1'b0;
               end
            end else begin
               s_d.cnt = s_q.cnt - timer_watchdog_pkg::CNT_ONE;
            end
         end else begin
            s_d.pre = s_q.pre - timer_watchdog_pkg::PRE_ONE;
         end
      end

      // Wave output
      if (eoc) begin
         s_d.wave = s_q.output_mode_bit ? s_q.pwm : ~s_q.wave;
      end
      s_d.out = s_q.output_enable_bit ? s_d.wave : 1'b1;

      // Reset request and interrupt routing
      s_d.wdg_rst = eoc & wdg;
      eoc_irq = eoc & ~wdg;
      s_d.a0_irq = s_q.ia0s ? s_q.sync_int[1] : eoc_irq;
      // With both selects clear only channel A0 carries the event
      s_d.top_irq = s_q.tlis ? s_q.sync_nmi[1] : (eoc_irq & s_q.ia0s);

      // Bus: address and data phases land in holding registers
      if (s_q.rsp.bvalid && axi_req.bready) begin
         s_d.rsp.bvalid = 1'b0;
      end
      if (s_q.rsp.awready && axi_req.awvalid) begin
         s_d.aw_full = 1'b1;
         s_d.waddr = axi_req.awaddr;
      end
      if (s_q.rsp.wready && axi_req.wvalid) begin
         s_d.w_full = 1'b1;
         s_d.wdata = axi_req.wdata;
         s_d.wstrb = axi_req.wstrb;
      end
      wr = s_q.aw_full & s_q.w_full & ~s_q.rsp.bvalid;
      wb = s_q.wdata[7:0];

      // Register write; byte lane 0 carries every register
      if (wr) begin
         s_d.aw_full = 1'b0;
         s_d.w_full = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         hit = 1'b1;
         unique case (s_q.waddr)
            timer_watchdog_pkg::OFS_CNT_HI: begin
               if (s_q.wstrb[0] && !wdg) begin
                  s_d.cons[15:8] = wb;
                  s_d.cons_new = 1'b1;
               end
            end
            timer_watchdog_pkg::OFS_CNT_LO: begin
               if (s_q.wstrb[0] && wdg) begin
                  if (wb == timer_watchdog_pkg::WDG_KEY1) begin
                     s_d.key_seen = 1'b1;
                  end else if (wb == timer_watchdog_pkg::WDG_KEY2 && s_q.key_seen) begin
                     s_d.key_seen = 1'b0;
                     s_d.cnt = s_q.cons;
                     s_d.pre = s_q.presc;
                     s_d.wdg_rst = 1'b0;
                  end else begin
                     s_d.key_seen = 1'b0;
                  end
               end else if (s_q.wstrb[0]) begin
                  s_d.cons[7:0] = wb;
                  s_d.cons_new = 1'b1;
               end
            end
            timer_watchdog_pkg::OFS_PRESC: begin
               if (s_q.wstrb[0]) begin
                  s_d.presc = wb;
                  s_d.pre = wb;
               end
            end
            timer_watchdog_pkg::OFS_CTRL: begin
               if (s_q.wstrb[0] && !wdg) begin
                  s_d.run = wb[timer_watchdog_pkg::CB_RUN];
                  s_d.sc = wb[timer_watchdog_pkg::CB_SC];
                  s_d.mode = {wb[timer_watchdog_pkg::CB_MODE_HI], wb[timer_watchdog_pkg::CB_MODE_LO]};
                  s_d.input_enable_bit = wb[timer_watchdog_pkg::CB_INPUT_ENABLE_BIT];
                  s_d.output_mode_bit = wb[timer_watchdog_pkg::CB_OUTPUT_MODE_BIT];
                  s_d.pwm = wb[timer_watchdog_pkg::CB_PWM];
                  s_d.output_enable_bit = wb[timer_watchdog_pkg::CB_OUTPUT_ENABLE_BIT];
                  if (wb[timer_watchdog_pkg::CB_RUN] && !s_q.run && s_q.cons_new) begin
                     s_d.cnt = s_q.cons;
                     s_d.pre = s_q.presc;
                     s_d.cons_new = 1'b0;
                  end
               end
            end
            timer_watchdog_pkg::OFS_WCTRL: begin
               if (s_q.wstrb[0] && !wb[timer_watchdog_pkg::WB_WDEN_N] && s_q.wden_n) begin
                  s_d.wden_n = 1'b0;
                  if (!s_q.hw_wdg) begin
                     s_d.cnt = s_q.cons;
                     s_d.pre = s_q.presc;
                     s_d.key_seen = 1'b0;
                  end
               end
            end
            timer_watchdog_pkg::OFS_IVSEL: begin
               if (s_q.wstrb[0]) begin
                  s_d.tlis = wb[timer_watchdog_pkg::IB_TLIS];
                  s_d.ia0s = wb[timer_watchdog_pkg::IB_IA0S];
               end
            end
            default: hit = 1'b0;
         endcase
         s_d.rsp.bresp = hit ? timer_watchdog_pkg::RESP_OKAY : timer_watchdog_pkg::RESP_SLVERR;
      end

      // Register read; counter halves show the live count
      if (s_q.rsp.rvalid && axi_req.rready) begin
         s_d.rsp.rvalid = 1'b0;
      end
      rd = s_q.rsp.arready & axi_req.arvalid;
      hit = 1'b1;
      unique case (axi_req.araddr)
         timer_watchdog_pkg::OFS_CNT_HI: rb = s_q.cnt[15:8];
         timer_watchdog_pkg::OFS_CNT_LO: rb = s_q.cnt[7:0];
         timer_watchdog_pkg::OFS_PRESC: rb = s_q.presc;
         timer_watchdog_pkg::OFS_CTRL: rb = {s_q.run, s_q.sc, s_q.mode, s_q.input_enable_bit, s_q.output_mode_bit, s_q.pwm, s_q.output_enable_bit};
         timer_watchdog_pkg::OFS_WCTRL: rb = {1'b0, s_q.wden_n, 6'h00};
         timer_watchdog_pkg::OFS_IVSEL: rb = {5'h00, s_q.tlis, s_q.ia0s, 1'b0};
         default: begin
            rb = 8'h00;
            hit = 1'b0;
         end
      endcase
      if (rd) begin
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rdata = {24'h000000, rb};
         s_d.rsp.rresp = hit ? timer_watchdog_pkg::RESP_OKAY : timer_watchdog_pkg::RESP_SLVERR;
      end

      // One write and one read at a time keep the slave simple
      s_d.rsp.awready = ~s_d.aw_full & ~s_d.rsp.bvalid;
      s_d.rsp.wready = ~s_d.w_full & ~s_d.rsp.bvalid;
      s_d.rsp.arready = ~s_d.rsp.rvalid;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= timer_watchdog_pkg::STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs straight from state
   // ----------------------------------------------------------------
   assign axi_rsp = s_q.rsp;
   assign timer_wave_output = s_q.out;
   assign wdg_reset_req = s_q.wdg_rst;
   assign top_level_irq = s_q.top_irq;
   assign chan_a0_irq = s_q.a0_irq;

endmodule : timer_watchdog_unit

// >>> bench/timer_watchdog_unit_properties.sv
// Bus contract and watchdog output properties of the timer/watchdog unit
`timescale 1ns/1ps

module timer_watchdog_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire timer_watchdog_pkg::axi_req_s axi_req,
   input wire timer_watchdog_pkg::axi_rsp_s axi_rsp,
   // Outputs
   input wire logic timer_wave_output,
   input wire logic wdg_reset_req
);
   // Read address kept until its answer, so unmapped reads can be judged
   logic [7:0] raddr_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         raddr_q <= 8'h00;
      end else if (axi_req.arvalid && axi_rsp.arready) begin
         raddr_q <= axi_req.araddr;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   rst_quiet_a:
      assert property ($rose(aresetn) |-> timer_wave_output && !wdg_reset_req && !axi_rsp.bvalid && !axi_rsp.rvalid)
      else $error("outputs not at rest after reset");
   wdg_pulse_a:
      assert property (wdg_reset_req |=> !wdg_reset_req)
      else $error("watchdog reset request longer than one cycle");
   b_answer_a:
      assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |-> ##2 axi_rsp.bvalid)
      else $error("write response late");
   b_hold_a:
      assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
      else $error("write response dropped");
   r_answer_a:
      assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
      else $error("read answer late");
   r_hold_a:
      assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
      else $error("read data dropped");
   r_unmapped_a:
      assert property (axi_rsp.rvalid && raddr_q > timer_watchdog_pkg::OFS_IVSEL
         |-> axi_rsp.rresp == timer_watchdog_pkg::RESP_SLVERR && axi_rsp.rdata == 32'h0)
      else $error("unmapped read not refused");
   r_mapped_a:
      assert property (axi_rsp.rvalid && raddr_q <= timer_watchdog_pkg::OFS_IVSEL && raddr_q[1:0] == 2'h0
         |-> axi_rsp.rresp == timer_watchdog_pkg::RESP_OKAY && axi_rsp.rdata[31:8] == 24'h0)
      else $error("mapped read wrong");
endmodule : timer_watchdog_checker

bind timer_watchdog_unit timer_watchdog_checker u_timer_watchdog_checker (.aclk(aclk), .aresetn(aresetn),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .timer_wave_output(timer_wave_output), .wdg_reset_req(wdg_reset_req));

// >>> bench/ext_side_model.sv
// Far side: event source on the count pin, watcher of wave output and system reset
`timescale 1ns/1ps

module ext_side_model (
   // Clock
   input wire logic aclk,
   // Command and pins
   input wire logic fire,
   output logic ext_count_input,
   input wire logic timer_wave_output,
   input wire logic wdg_reset_req,
   // Tallies
   output int wave_edges,
   output int rst_seen
);
   int gap;
   logic wave_q;
   initial begin
      gap = 0;
      wave_q = 1'b1;
      wave_edges = 0;
      rst_seen = 0;
      ext_count_input = 1'b1;
   end
   // Four low cycles per pulse, low as long as fire is held; the gap keeps falling edges apart
   always @(posedge aclk) begin
      if (fire && gap == 0) begin
         gap <= 10;
      end else if (gap > 0) begin
         gap <= gap - 1;
      end
      ext_count_input <= !(gap > 7 || fire);
      wave_q <= timer_wave_output;
      if (wave_q !== timer_wave_output) wave_edges <= wave_edges + 1;
      if (wdg_reset_req === 1'b1) rst_seen <= rst_seen + 1;
   end
endmodule : ext_side_model

// >>> bench/tb_top.sv
// Self-checking testbench of the timer/watchdog unit
`timescale 1ns/1ps

module tb_top;
   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   timer_watchdog_pkg::axi_req_s req = '0;
   timer_watchdog_pkg::axi_rsp_s rsp;
   logic ext_int_pin = 1'b0;
   logic nmi_pin = 1'b0;
   logic cpu_halt = 1'b0;
   logic fire = 1'b0;
   logic hw_sel = 1'b1;
   logic ext_count_input, wave, wdg_rst, irq_top, irq_a0;
   int wave_edges, rst_seen, err_total = 0, num_checks = 0;
   logic [7:0] rst_tab [6] = '{8'hFF, 8'hFF, 8'hFF, 8'h12, 8'h40, 8'h06};

   // 100 MHz clock
   always #5 aclk = ~aclk;

   timer_watchdog_unit u_timer_watchdog_unit (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .ext_count_input(ext_count_input), .ext_int_pin(ext_int_pin), .nmi_pin(nmi_pin),
      .hw_watchdog_select_pin(hw_sel), .cpu_halt(cpu_halt), .timer_wave_output(wave),
      .wdg_reset_req(wdg_rst), .top_level_irq(irq_top), .chan_a0_irq(irq_a0));
   ext_side_model u_ext_side_model (.aclk(aclk), .fire(fire), .ext_count_input(ext_count_input),
      .timer_wave_output(wave), .wdg_reset_req(wdg_rst), .wave_edges(wave_edges), .rst_seen(rst_seen));

   // ---------------------------------------------
   // Bus and helper tasks
   // ---------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Address and data offered together; each dropped once taken
   // Response ready stays high between calls, so no edge sees it dropped and raised at once
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
         if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      d = rsp.rdata;
      r = rsp.rresp;
   endtask : rd

   // A window of whole periods holds the same count of ends whatever its phase
   task automatic win(input int c, output int np, output int nw, output int nr);
      int w0, r0;
      w0 = wave_edges;
      r0 = rst_seen;
      np = 0;
      repeat (c) begin
         @(posedge aclk);
         if (irq_a0 === 1'b1) np++;
      end
      nw = wave_edges - w0;
      nr = rst_seen - r0;
   endtask : win

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 6; i++) begin
         rd(8'(4 * i), d, r);
         chk(d, {24'h0, rst_tab[i]});
      end
      rd(8'h18, d, r);
      chk({30'h0, r}, {30'h0, timer_watchdog_pkg::RESP_SLVERR});
      chk({31'h0, wave}, 32'h1);
      nmi_pin <= 1'b1;
      ext_int_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      chk({30'h0, irq_top, irq_a0}, 32'h3);
      nmi_pin <= 1'b0;
      ext_int_pin <= 1'b0;
      $display("test reset done");
   endtask : t_reset

   task automatic t_cont();
      int np, nw, nr;
      wr(8'h14, 32'h0);
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h3);
      wr(8'h08, 32'h0);
      wr(8'h0C, 32'h91);
      win(40, np, nw, nr);
      win(160, np, nw, nr);
      chk(32'(np), 32'hA);
      chk(32'(nw), 32'hA);
      wr(8'h08, 32'h1);
      win(40, np, nw, nr);
      win(320, np, nw, nr);
      chk(32'(np), 32'hA);
      $display("test continuous done");
   endtask : t_cont

   task automatic t_single();
      int np, nw, nr;
      logic [31:0] d;
      logic [1:0] r;
      wr(8'h0C, 32'h11);
      wr(8'h04, 32'h5);
      wr(8'h08, 32'h0);
      wr(8'h0C, 32'hD1);
      win(100, np, nw, nr);
      chk(32'(np), 32'h1);
      rd(8'h0C, d, r);
      chk(d, 32'h51);
      rd(8'h04, d, r);
      chk(d, 32'h5);
      $display("test single done");
   endtask : t_single

   task automatic t_pwm();
      int np, nw, nr;
      wr(8'h0C, 32'h95);
      win(60, np, nw, nr);
      chk({31'h0, wave}, 32'h0);
      wr(8'h0C, 32'h97);
      win(60, np, nw, nr);
      chk({31'h0, wave}, 32'h1);
      wr(8'h0C, 32'h95);
      win(60, np, nw, nr);
      wr(8'h0C, 32'h94);
      repeat (2) @(posedge aclk);
      chk({31'h0, wave}, 32'h1);
      $display("test output modes done");
   endtask : t_pwm

   // Each event pulse is followed by a counting window
   task automatic pulse_in(input int n, output int np);
      int a, b, c;
      np = 0;
      repeat (n) begin
         fire <= 1'b1;
         @(posedge aclk);
         fire <= 1'b0;
         win(14, a, b, c);
         np += a;
      end
   endtask : pulse_in

   task automatic t_event();
      int np;
      wr(8'h0C, 32'h08);
      wr(8'h04, 32'h1);
      pulse_in(2, np);
      chk(32'(np), 32'h0);
      wr(8'h0C, 32'h88);
      pulse_in(4, np);
      chk(32'(np), 32'h2);
      $display("test event done");
   endtask : t_event

   // Triggered, gated and retriggered counting of the internal clock/4
   task automatic t_modes();
      int np, nw, nr;
      wr(8'h0C, 32'h28);
      wr(8'h0C, 32'hA8);
      win(40, np, nw, nr);
      chk(32'(np), 32'h0);
      pulse_in(1, np);
      win(80, np, nw, nr);
      chk(32'(np), 32'hA);
      wr(8'h0C, 32'h98);
      fire <= 1'b1;
      repeat (8) @(posedge aclk);
      win(80, np, nw, nr);
      chk(32'(np), 32'h0);
      fire <= 1'b0;
      repeat (12) @(posedge aclk);
      win(80, np, nw, nr);
      chk(32'(np), 32'hA);
      wr(8'h0C, 32'h38);
      wr(8'h04, 32'h8);
      wr(8'h0C, 32'hB8);
      pulse_in(4, np);
      chk(32'(np), 32'h0);
      win(72, np, nw, nr);
      chk(32'(np), 32'h2);
      $display("test input modes done");
   endtask : t_modes

   task automatic t_wdg();
      int np, nw, nr, tot;
      logic [31:0] d;
      logic [1:0] r;
      wr(8'h0C, 32'h00);
      wr(8'h04, 32'h10);
      wr(8'h10, 32'h00);
      cpu_halt <= 1'b1;
      tot = 0;
      repeat (6) begin
         wr(8'h04, 32'hAA);
         wr(8'h04, 32'h55);
         win(30, np, nw, nr);
         tot += nr;
      end
      chk(32'(tot), 32'h0);
      wr(8'h10, 32'h40);
      rd(8'h10, d, r);
      chk(d, 32'h0);
      win(136, np, nw, nr);
      chk(32'(nr), 32'h2);
      $display("test watchdog done");
   endtask : t_wdg

   // Second reset with the strap low: watchdog forced, constant fixed at all ones
   task automatic t_hwdg();
      logic [31:0] d;
      logic [1:0] r;
      hw_sel <= 1'b0;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      wr(8'h08, 32'h0);
      wr(8'h00, 32'h0);
      wr(8'h0C, 32'h80);
      wr(8'h04, 32'hAA);
      wr(8'h04, 32'h55);
      rd(8'h00, d, r);
      chk(d, 32'hFF);
      rd(8'h0C, d, r);
      chk(d, 32'h12);
      rd(8'h10, d, r);
      chk(d, 32'h40);
      repeat (40) @(posedge aclk);
      rd(8'h04, d, r);
      chk({31'h0, d[7:0] != 8'hFF}, 32'h1);
      $display("test hardware watchdog done");
   endtask : t_hwdg

   // ---------------------------------------------
   // Run and verdict
   // ---------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_cont();
      t_single();
      t_pwm();
      t_event();
      t_modes();
      t_wdg();
      t_hwdg();
      give_verdict();
   end

   // Hang guard, well above the roughly 2000 cycles the tests take
   initial begin
      repeat (8000) @(posedge aclk);
      err_total++;
      give_verdict();
   end
endmodule : tb_top
